/* src/event_pin_io.sv */
// Event pin synchroniser, edge detector and toggle driver
`timescale 1ns/1ps
module event_pin_io (
   input  wire logic       i_clock,
   input  wire logic       i_rst_n,
   input  wire logic       i_pin_in,
   input  wire logic [1:0] i_dir,
   input  wire logic       i_toggle_req,
   output logic            o_pin_out,
   output logic            o_pin_oe,
   output logic            o_edge,
   output logic            o_level
);
   import event_symbol_pkg::*;

   logic                   sync1_q;
   logic                   sync2_q;
   logic                   sync3_q;
   logic                   level_q;
   logic                   pin_out_q;
   logic [GAP_CNT_W-1:0]   gap_q;

   // ***********************************
   // Input synchroniser
   // ***********************************
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync1_q <= PIN_IDLE_LEVEL;
         sync2_q <= PIN_IDLE_LEVEL;
         sync3_q <= PIN_IDLE_LEVEL;
      end else begin
         sync1_q <= i_pin_in;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         level_q <= PIN_IDLE_LEVEL;
      end else if (sync2_q == sync3_q) begin
         level_q <= sync3_q;
      end
   end

   // One pulse per settled transition while in input mode
   assign o_edge  = (sync2_q == sync3_q) && (sync3_q != level_q)
                    && (i_dir == DIR_INPUT);
   assign o_level = level_q;

   // ***********************************
   // Toggle driver
   // ***********************************
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pin_out_q <= PIN_IDLE_LEVEL;
         gap_q     <= '0;
      end else if (i_toggle_req && (gap_q == '0) && (i_dir == DIR_OUTPUT)) begin
         pin_out_q <= ~pin_out_q;
         gap_q     <= GAP_CNT_W'(EVENT_GAP_CYC - 1);
      end else if (gap_q != '0) begin
         gap_q     <= gap_q - GAP_CNT_W'(1);
      end
   end

   assign o_pin_out = pin_out_q;
   assign o_pin_oe  = (i_dir == DIR_OUTPUT);
endmodule // event_pin_io

/* src/event_symbol_forwarder.sv */
// Event symbol forwarding, interrupts, event pin and register slave
//
// Notes on behaviour
// - A symbol received on one port is announced to every other port.
// - A notified port sends a symbol only if its forward enable bit is 1.
// - Each reception raises a port interrupt, masked by its select bit.
// - Per-port status bits kept; their OR shows in port and global status.
// - Writing 1 clears status for one port or for all ports.
// - In output mode the pin toggles per symbol, first symbol drives it low.
// - The interrupt select bits choose which ports toggle the pin.
// - The pin drives only when direction control equals binary 10.
// - A send write is answered once its symbol is queued.
// - Send writes are ignored while any symbol is pending or in flight.
// - JTAG and I2C may write the send register too.
// - In input mode each pin transition makes every enabled port send one.
// - Of symbols too close together one is forwarded, the rest dropped.
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module event_symbol_forwarder (
   input  wire logic                                  i_clock,
   input  wire logic                                  i_rst_n,
   // AXI4-Lite slave
   input  wire logic [event_symbol_pkg::ADDR_W-1:0]   i_awaddr,
   input  wire logic                                  i_awvalid,
   output logic                                       o_awready,
   input  wire logic [31:0]                           i_wdata,
   input  wire logic [3:0]                            i_wstrb,
   input  wire logic                                  i_wvalid,
   output logic                                       o_wready,
   output logic [1:0]                                 o_bresp,
   output logic                                       o_bvalid,
   input  wire logic                                  i_bready,
   input  wire logic [event_symbol_pkg::ADDR_W-1:0]   i_araddr,
   input  wire logic                                  i_arvalid,
   output logic                                       o_arready,
   output logic [31:0]                                o_rdata,
   output logic [1:0]                                 o_rresp,
   output logic                                       o_rvalid,
   input  wire logic                                  i_rready,
   // Send register side paths
   input  wire logic                                  i_jtag_send,
   input  wire logic                                  i_i2c_send,
   // Serial ports
   input  wire logic [event_symbol_pkg::NUM_PORTS-1:0] i_rx_event,
   output logic      [event_symbol_pkg::NUM_PORTS-1:0] o_tx_event_req,
   input  wire logic [event_symbol_pkg::NUM_PORTS-1:0] i_tx_event_enq,
   input  wire logic [event_symbol_pkg::NUM_PORTS-1:0] i_tx_event_done,
   // Event pin and interrupt
   input  wire logic                                  i_event_pin,
   output logic                                       o_event_pin,
   output logic                                       o_event_pin_oe,
   output logic                                       o_irq
);
   import event_symbol_pkg::*;

   // ***********************************
   // Helpers
   // ***********************************
   function automatic logic [31:0] strobe_mask(input logic [3:0] strb);
      strobe_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
   endfunction

   function automatic logic [NUM_PORTS-1:0] lowest_one(input logic [NUM_PORTS-1:0] v);
      lowest_one = v & (~v + NUM_PORTS'(1));
   endfunction

   // ***********************************
   // Declarations
   // ***********************************
   wr_state_t              wr_state_q;
   logic                   aw_got_q;
   logic                   w_got_q;
   logic [ADDR_W-1:0]      awaddr_q;
   logic [31:0]            wdata_q;
   logic [3:0]             wstrb_q;
   logic [1:0]             bresp_q;
   logic                   rvalid_q;
   logic [31:0]            rdata_q;
   logic [1:0]             rresp_q;
   logic [31:0]            ctrl_q;
   logic [31:0]            mask_q;
   logic [NUM_PORTS-1:0]   status_q;
   logic                   do_write;
   logic [31:0]            wmask;
   logic                   wr_send;
   logic                   sw_launch;
   logic [NUM_PORTS-1:0]   fwd_en;
   logic [NUM_PORTS-1:0]   int_sel;
   logic [1:0]             pin_dir;
   logic                   status_any;
   logic                   rx_any;
   logic [NUM_PORTS-1:0]   rx_src;
   logic                   pin_edge;
   logic                   pin_level;
   logic                   launch;
   logic [NUM_PORTS-1:0]   launch_mask;
   logic                   tx_queued;
   logic                   tx_busy;

   assign fwd_en     = ctrl_q[CTRL_FWD_LSB +: NUM_PORTS];
   assign int_sel    = ctrl_q[CTRL_SEL_LSB +: NUM_PORTS];
   assign pin_dir    = ctrl_q[CTRL_DIR_LSB +: 2];
   assign status_any = |status_q;

   // ***********************************
   // Write channel
   // ***********************************
   assign o_awready = !aw_got_q && (wr_state_q == WR_IDLE);
   assign o_wready  = !w_got_q && (wr_state_q == WR_IDLE);
   assign o_bvalid  = (wr_state_q == WR_RESP);
   assign o_bresp   = bresp_q;
   assign do_write  = (wr_state_q == WR_IDLE) && aw_got_q && w_got_q;
   assign wmask     = strobe_mask(wstrb_q);
   assign wr_send   = do_write && (awaddr_q == ADDR_SEND) && (wstrb_q != 4'h0);

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         aw_got_q <= 1'b0;
         awaddr_q <= '0;
      end else if (i_awvalid && o_awready) begin
         aw_got_q <= 1'b1;
         awaddr_q <= i_awaddr;
      end else if (do_write) begin
         aw_got_q <= 1'b0;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         w_got_q <= 1'b0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else if (i_wvalid && o_wready) begin
         w_got_q <= 1'b1;
         wdata_q <= i_wdata;
         wstrb_q <= i_wstrb;
      end else if (do_write) begin
         w_got_q <= 1'b0;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_state_q <= WR_IDLE;
         bresp_q    <= RESP_OKAY;
      end else begin
         unique case (wr_state_q)
            WR_IDLE: begin
               if (do_write) begin
                  bresp_q    <= (awaddr_q > ADDR_STATE || awaddr_q[1:0] != 2'h0)
                                ? RESP_SLVERR : RESP_OKAY;
                  wr_state_q <= (wr_send && sw_launch) ? WR_WAIT_ENQ : WR_RESP;
               end
            end
            WR_WAIT_ENQ: begin
               if (tx_queued) begin
                  wr_state_q <= WR_RESP;
               end
            end
            WR_RESP: begin
               if (i_bready) begin
                  wr_state_q <= WR_IDLE;
               end
            end
            default: begin
               wr_state_q <= WR_IDLE;
            end
         endcase
      end
   end

   // ***********************************
   // Registers
   // ***********************************
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl_q <= CTRL_RESET;
      end else if (do_write && awaddr_q == ADDR_CTRL) begin
         ctrl_q <= (ctrl_q & ~wmask) | (wdata_q & wmask);
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mask_q <= MASK_RESET;
      end else if (do_write && awaddr_q == ADDR_INT_MASK) begin
         mask_q <= (mask_q & ~wmask) | (wdata_q & wmask);
      end
   end

   // Sticky status, set wins over clear
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         status_q <= '0;
      end else if (do_write && awaddr_q == ADDR_INT_STATUS) begin
         if (wdata_q[INT_ALL_BIT] && wmask[INT_ALL_BIT]) begin
            status_q <= i_rx_event;
         end else begin
            status_q <= (status_q & ~(wdata_q[NUM_PORTS-1:0] & wmask[NUM_PORTS-1:0]))
                        | i_rx_event;
         end
      end else begin
         status_q <= status_q | i_rx_event;
      end
   end

   assign o_irq = |(status_q & mask_q[NUM_PORTS-1:0] & ~int_sel);

   // ***********************************
   // Read channel
   // ***********************************
   assign o_arready = !rvalid_q;
   assign o_rvalid  = rvalid_q;
   assign o_rdata   = rdata_q;
   assign o_rresp   = rresp_q;

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rvalid_q <= 1'b0;
         rdata_q  <= '0;
         rresp_q  <= RESP_OKAY;
      end else if (i_arvalid && o_arready) begin
         rvalid_q <= 1'b1;
         rresp_q  <= RESP_OKAY;
         rdata_q  <= '0;
         unique case (i_araddr)
            ADDR_CTRL:       rdata_q <= ctrl_q;
            ADDR_INT_STATUS: begin
               rdata_q[NUM_PORTS-1:0] <= status_q;
               rdata_q[INT_ALL_BIT]   <= status_any;
            end
            ADDR_INT_MASK:   rdata_q <= mask_q;
            ADDR_GLOBAL:     rdata_q[0] <= status_any;
            ADDR_SEND:       rdata_q[STATE_BUSY_BIT] <= tx_busy;
            ADDR_STATE: begin
               rdata_q[STATE_BUSY_BIT] <= tx_busy;
               rdata_q[STATE_OUT_BIT]  <= o_event_pin;
               rdata_q[STATE_IN_BIT]   <= pin_level;
            end
            default:         rresp_q <= RESP_SLVERR;
         endcase
      end else if (i_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // ***********************************
   // Symbol launch
   // ***********************************
   assign rx_any    = |i_rx_event;
   assign rx_src    = lowest_one(i_rx_event);
   assign sw_launch = (wr_send || i_jtag_send || i_i2c_send) && !tx_busy
                      && !rx_any && !pin_edge;
   assign launch    = rx_any || pin_edge || sw_launch;

   always_comb begin
      if (rx_any) begin
         launch_mask = fwd_en & ~rx_src;
      end else begin
         launch_mask = fwd_en;
      end
   end

   event_tx_tracker u_tracker (
      .i_clock   (i_clock),
      .i_rst_n   (i_rst_n),
      .i_launch  (launch),
      .i_mask    (launch_mask),
      .i_tx_enq  (i_tx_event_enq),
      .i_tx_done (i_tx_event_done),
      .o_tx_req  (o_tx_event_req),
      .o_queued  (tx_queued),
      .o_busy    (tx_busy)
   );

   // ***********************************
   // Event pin
   // ***********************************
   event_pin_io u_pin (
      .i_clock      (i_clock),
      .i_rst_n      (i_rst_n),
      .i_pin_in     (i_event_pin),
      .i_dir        (pin_dir),
      .i_toggle_req (|(i_rx_event & int_sel)),
      .o_pin_out    (o_event_pin),
      .o_pin_oe     (o_event_pin_oe),
      .o_edge       (pin_edge),
      .o_level      (pin_level)
   );
endmodule // event_symbol_forwarder

/* src/event_symbol_pkg.sv */
// Constants, register map and types of the multicast event symbol block
package event_symbol_pkg;
   // ***********************************
   // Sizes
   // ***********************************
   localparam int          NUM_PORTS       = 4;
   localparam int          ADDR_W          = 8;

   // ***********************************
   // Register offsets
   // ***********************************
   localparam logic [7:0]  ADDR_CTRL       = 8'h00;
   localparam logic [7:0]  ADDR_INT_STATUS = 8'h04;
   localparam logic [7:0]  ADDR_INT_MASK   = 8'h08;
   localparam logic [7:0]  ADDR_GLOBAL     = 8'h0C;
   localparam logic [7:0]  ADDR_SEND       = 8'h10;
   localparam logic [7:0]  ADDR_STATE      = 8'h14;

   // ***********************************
   // Field positions and values
   // ***********************************
   localparam int          CTRL_FWD_LSB    = 0;
   localparam int          CTRL_SEL_LSB    = 4;
   localparam int          CTRL_DIR_LSB    = 8;
   localparam int          INT_ALL_BIT     = 31;
   localparam int          STATE_BUSY_BIT  = 0;
   localparam int          STATE_OUT_BIT   = 1;
   localparam int          STATE_IN_BIT    = 2;
   localparam logic [1:0]  DIR_OUTPUT      = 2'h2;
   localparam logic [1:0]  DIR_INPUT       = 2'h1;
   localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
   localparam logic [31:0] MASK_RESET      = 32'h0000_0000;
   localparam logic        PIN_IDLE_LEVEL  = 1'b1;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   // ***********************************
   // Timing
   // ***********************************
   localparam int          CLOCK_PERIOD_NS = 40;
   localparam int          EVENT_GAP_NS    = 500;
   localparam int          EVENT_GAP_CYC   = (EVENT_GAP_NS + CLOCK_PERIOD_NS - 1)
                                             / CLOCK_PERIOD_NS;
   localparam int          GAP_CNT_W       = 4;

   // ***********************************
   // Types
   // ***********************************
   typedef enum logic [1:0] {
      WR_IDLE     = 2'b00,
      WR_WAIT_ENQ = 2'b01,
      WR_RESP     = 2'b10
   } wr_state_t;
endpackage

/* src/event_tx_tracker.sv */
// Per-port transmit request and in-flight tracking
`timescale 1ns/1ps
module event_tx_tracker (
   input  wire logic                                  i_clock,
   input  wire logic                                  i_rst_n,
   input  wire logic                                  i_launch,
   input  wire logic [event_symbol_pkg::NUM_PORTS-1:0] i_mask,
   input  wire logic [event_symbol_pkg::NUM_PORTS-1:0] i_tx_enq,
   input  wire logic [event_symbol_pkg::NUM_PORTS-1:0] i_tx_done,
   output logic      [event_symbol_pkg::NUM_PORTS-1:0] o_tx_req,
   output logic                                       o_queued,
   output logic                                       o_busy
);
   import event_symbol_pkg::*;

   logic [NUM_PORTS-1:0]   pend_q;
   logic [NUM_PORTS-1:0]   flight_q;

   // ***********************************
   // Pending and in-flight masks
   // ***********************************
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pend_q <= '0;
      end else if (i_launch && !o_busy) begin
         pend_q <= i_mask;
      end else begin
         pend_q <= pend_q & ~i_tx_enq;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         flight_q <= '0;
      end else begin
         flight_q <= (flight_q & ~i_tx_done) | (pend_q & i_tx_enq);
      end
   end

   assign o_tx_req = pend_q;
   assign o_queued = (pend_q == '0);
   assign o_busy   = (pend_q != '0) || (flight_q != '0);
endmodule // event_tx_tracker

/* testbench/event_symbol_assertions.sv */
// Port assertions of the forwarder
`timescale 1ns/1ps
module event_symbol_assertions (
   input wire logic                                   i_clock,
   input wire logic                                   i_rst_n,
   input wire logic                                   o_awready,
   input wire logic                                   o_wready,
   input wire logic                                   o_bvalid,
   input wire logic                                   i_arvalid,
   input wire logic                                   o_arready,
   input wire logic                                   o_rvalid,
   input wire logic [event_symbol_pkg::NUM_PORTS-1:0] i_rx_event,
   input wire logic [event_symbol_pkg::NUM_PORTS-1:0] o_tx_event_req,
   input wire logic [event_symbol_pkg::NUM_PORTS-1:0] i_tx_event_enq,
   input wire logic                                   o_event_pin,
   input wire logic                                   o_event_pin_oe,
   input wire logic                                   o_irq
);
   import event_symbol_pkg::*;
   // ****************
   // Checks
   // ****************
   default clocking @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_n);

   AST_REQ_HOLD: assert property (
      &(o_tx_event_req | ~$past(o_tx_event_req) | $past(i_tx_event_enq)))
      else $error("Request fell early");
   AST_REQ_DROP: assert property (
      (o_tx_event_req & $past(o_tx_event_req) & $past(i_tx_event_enq)) == 0)
      else $error("Request held after enqueue");
   AST_SRC_SKIPPED: assert property (
      $onehot(i_rx_event) && o_tx_event_req == 0
      |=> (o_tx_event_req & $past(i_rx_event)) == 0)
      else $error("Source port requested");
   AST_PIN_GAP: assert property (
      $changed(o_event_pin) |=> $stable(o_event_pin) [*8])
      else $error("Pin toggled too soon");
   AST_PIN_CAUSE: assert property (
      $changed(o_event_pin) |-> $past(i_rx_event) != 0)
      else $error("Pin toggled without symbol");
   AST_IRQ_CAUSE: assert property (
      $rose(o_irq) |-> $past(i_rx_event) != 0 || !$past(o_wready))
      else $error("Irq rose without cause");
   AST_OE_CAUSE: assert property (
      $changed(o_event_pin_oe) |-> !$past(o_wready))
      else $error("Oe changed without write");
   AST_WR_REFUSE: assert property (
      o_bvalid |-> !o_awready && !o_wready)
      else $error("Write ready during response");
   AST_READ_LAT: assert property (
      i_arvalid && o_arready |=> o_rvalid && !o_arready)
      else $error("Read data late");
endmodule // event_symbol_assertions

bind event_symbol_forwarder event_symbol_assertions u_check (.*);

/* testbench/link_partner_model.sv */
// Link partner model
`timescale 1ns/1ps
module link_partner_model (
   input  wire logic                                  i_clock,
   input  wire logic                                  i_rst_n,
   input  wire logic                                  i_slow,
   input  wire logic [event_symbol_pkg::NUM_PORTS-1:0] i_req,
   output logic      [event_symbol_pkg::NUM_PORTS-1:0] o_enq,
   output logic      [event_symbol_pkg::NUM_PORTS-1:0] o_done
);
   import event_symbol_pkg::*;
   logic [NUM_PORTS-1:0] sent_q;
   int                   wait_q;
   int                   hold_q;
   // ****************
   // Enqueue then transmit
   // ****************
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_enq  <= '0;
         o_done <= '0;
         sent_q <= '0;
         wait_q <= 0;
         hold_q <= 0;
      end else begin
         o_enq  <= '0;
         o_done <= '0;
         if (wait_q != 0) begin
            wait_q <= wait_q - 1;
         end else if (sent_q != 0) begin
            o_done <= sent_q;
            sent_q <= '0;
         end else if (i_req != 0 && o_enq == 0) begin
            if (hold_q >= (i_slow ? 20 : 0)) begin
               o_enq  <= i_req;
               sent_q <= i_req;
               wait_q <= i_slow ? 20 : 0;
               hold_q <= 0;
            end else begin
               hold_q <= hold_q + 1;
            end
         end
      end
   end
endmodule // link_partner_model

/* testbench/multicast_event_symbol_forwarding_tb.sv */
// Self-checking bench of the event symbol forwarder
`timescale 1ns/1ps
module multicast_event_symbol_forwarding_tb;
   import event_symbol_pkg::*;
   logic                 clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
   logic                 jtag, i2c, host_pin, slow, pin_wire;
   logic                 awready, wready, bvalid, arready, rvalid, pout, poe, irq;
   logic [7:0]           awaddr, araddr;
   logic [31:0]          wdata, rdata;
   logic [1:0]           bresp, rresp;
   logic [NUM_PORTS-1:0] rx, txreq, enq, done, last_mask;
   logic [NUM_PORTS-1:0] prev_req;
   int                   error_cnt = 0;
   int                   checks_done = 0;
   int                   launches = 0;
   int                   enq_cnt = 0;

   assign pin_wire = poe ? pout : host_pin;
   event_symbol_forwarder DUT (
      .i_clock(clk), .i_rst_n(rst_n), .i_awaddr(awaddr), .i_awvalid(awvalid),
      .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid),
      .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
      .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
      .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_jtag_send(jtag),
      .i_i2c_send(i2c), .i_rx_event(rx), .o_tx_event_req(txreq),
      .i_tx_event_enq(enq), .i_tx_event_done(done), .i_event_pin(pin_wire),
      .o_event_pin(pout), .o_event_pin_oe(poe), .o_irq(irq));
   link_partner_model partner (
      .i_clock(clk), .i_rst_n(rst_n), .i_slow(slow), .i_req(txreq),
      .o_enq(enq), .o_done(done));

   // ****************
   // Monitors and helpers
   // ****************
   always @(negedge clk) begin
      if (txreq != 0 && prev_req == 0) begin
         launches++;
         last_mask = txreq;
      end
      prev_req = txreq;
      if (enq != 0) enq_cnt++;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      {awaddr, wdata} <= {a, d};
      {awvalid, wvalid, bready} <= 3'h7;
      do begin
         @(posedge clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      {araddr, arvalid, rready} <= {a, 2'h3};
      do begin
         @(posedge clk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
   endtask

   task automatic wait_idle;
      logic [31:0] d;
      logic [1:0]  r;
      int          n = 0;
      do begin
         axi_rd(ADDR_STATE, d, r);
         n++;
      end while (d[STATE_BUSY_BIT] !== 1'b0 && n < 100);
      check(d[STATE_BUSY_BIT], 1'b0);
   endtask

   task automatic wait_launch(input int n0);
      for (int i = 0; i < 60 && launches == n0; i++) @(posedge clk);
   endtask

   task automatic rx_pulse(input int p);
      rx <= 4'h1 << p;
      @(posedge clk);
      rx <= '0;
      @(posedge clk);
   endtask

   // ****************
   // Scenarios
   // ****************
   task automatic test_regs;
      logic [31:0] d;
      logic [1:0]  r;
      axi_rd(ADDR_CTRL, d, r);
      check(d, CTRL_RESET);
      axi_rd(ADDR_INT_MASK, d, r);
      check(d, MASK_RESET);
      axi_rd(8'h18, d, r);
      check(r, RESP_SLVERR);
      axi_wr(8'h18, 32'h0, r);
      check(r, RESP_SLVERR);
      $display("test_regs done");
   endtask

   task automatic test_pin;
      logic [1:0] r;
      for (int k = 0; k < 4; k++) begin
         axi_wr(ADDR_CTRL, {22'h0, 2'(k), 8'h10}, r);
         check(poe, k == 2);
      end
      axi_wr(ADDR_CTRL, 32'h210, r);
      check(pout, PIN_IDLE_LEVEL);
      for (int k = 0; k < 3; k++) begin
         rx_pulse(k == 1);
         repeat (20) @(posedge clk);
         check(pout, k == 2);
      end
      $display("test_pin done");
   endtask

   task automatic test_fwd;
      logic [31:0]          d;
      logic [1:0]           r;
      logic [NUM_PORTS-1:0] fwd;
      axi_wr(ADDR_INT_MASK, 32'hF, r);
      for (int p = 0; p < NUM_PORTS; p++) begin
         fwd = (p == 0) ? 4'hA : 4'hF;
         axi_wr(ADDR_CTRL, {28'h0, fwd}, r);
         rx_pulse(p);
         check(txreq, fwd & ~(4'h1 << p));
         wait_idle;
      end
      axi_rd(ADDR_INT_STATUS, d, r);
      check(d, 32'h8000000F);
      axi_rd(ADDR_GLOBAL, d, r);
      check(d, 32'h1);
      check(irq, 1'b1);
      $display("test_fwd done");
   endtask

   task automatic test_int;
      logic [31:0] d;
      logic [1:0]  r;
      axi_wr(ADDR_CTRL, 32'hF0, r);
      check(irq, 1'b0);
      axi_wr(ADDR_CTRL, 32'h0, r);
      axi_wr(ADDR_INT_STATUS, 32'h1, r);
      axi_rd(ADDR_INT_STATUS, d, r);
      check(d, 32'h8000000E);
      check(irq, 1'b1);
      axi_wr(ADDR_INT_STATUS, 32'h80000000, r);
      axi_rd(ADDR_GLOBAL, d, r);
      check(d, 32'h0);
      check(irq, 1'b0);
      $display("test_int done");
   endtask

   task automatic test_sw;
      logic [31:0] d;
      logic [1:0]  r;
      int          n0, e0;
      axi_wr(ADDR_CTRL, 32'h3, r);
      slow <= 1'b1;
      n0 = launches;
      e0 = enq_cnt;
      axi_wr(ADDR_SEND, 32'h1, r);
      check(enq_cnt - e0, 1);
      check(txreq, 4'h0);
      axi_wr(ADDR_SEND, 32'h1, r);
      check(r, RESP_OKAY);
      axi_rd(ADDR_STATE, d, r);
      check(d[STATE_BUSY_BIT], 1'b1);
      wait_idle;
      check(launches - n0, 1);
      for (int k = 0; k < 2; k++) begin
         n0 = launches;
         {i2c, jtag} <= 2'b01 << k;
         @(posedge clk);
         {i2c, jtag} <= 2'b00;
         wait_launch(n0);
         check(last_mask, 4'h3);
         wait_idle;
         check(launches - n0, 1);
      end
      slow <= 1'b0;
      $display("test_sw done");
   endtask

   task automatic test_pin_in;
      logic [1:0] r;
      int         n0;
      axi_wr(ADDR_CTRL, 32'h105, r);
      for (int k = 0; k < 2; k++) begin
         n0 = launches;
         host_pin <= ~host_pin;
         wait_launch(n0);
         check(last_mask, 4'h5);
         repeat (30) @(posedge clk);
         check(launches - n0, 1);
      end
      $display("test_pin_in done");
   endtask

   task automatic test_drop;
      logic [1:0] r;
      int         n0;
      axi_wr(ADDR_CTRL, 32'hF, r);
      slow <= 1'b1;
      n0 = launches;
      rx_pulse(0);
      rx_pulse(2);
      wait_idle;
      check(launches - n0, 1);
      check(last_mask, 4'hE);
      slow <= 1'b0;
      $display("test_drop done");
   endtask

   task automatic final_report;
      $display("Checks %0d, errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ****************
   // Clock, reset, sequence
   // ****************
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial begin
      rst_n = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, jtag, i2c, slow} = '0;
      {awaddr, araddr, wdata, rx} = '0;
      host_pin = 1'b1;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      test_regs;
      test_pin;
      test_fwd;
      test_int;
      test_sw;
      test_pin_in;
      test_drop;
      final_report;
   end

   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      final_report;
   end
endmodule // multicast_event_symbol_forwarding_tb
